//--- rtl/crsp_clkgen.v
// Runt-free output clock with full or half rate
`timescale 1ns/1ps
module crsp_clkgen #(
  parameter HALF_CYC = 1
) (
  input  wire clk,
  input  wire rst_b,
  input  wire run,
  input  wire half_req,
  output wire clk_out,
  output wire active,
  output wire half_active
);

  reg        out_reg;
  reg        active_reg;
  reg        half_reg;
  reg [15:0] cnt_reg;
  wire [15:0] limit;

  localparam [31:0] FULL_LAST_W = HALF_CYC - 1;
  localparam [31:0] HALF_LAST_W = 2 * HALF_CYC - 1;

  // Half rate doubles every phase, so the period doubles exactly
  assign limit = half_reg ? HALF_LAST_W[15:0] : FULL_LAST_W[15:0];

  // Rate and run are only sampled at a period boundary, never mid-phase
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_reg    <= 1'b0;
      active_reg <= 1'b0;
      half_reg   <= 1'b0;
      cnt_reg    <= 16'h0000;
    end else if (!active_reg) begin
      out_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      if (run) begin
        active_reg <= 1'b1;
        half_reg   <= half_req;
        out_reg    <= 1'b1;
      end
    end else if (cnt_reg == limit) begin
      cnt_reg <= 16'h0000;
      if (out_reg) begin
        out_reg <= 1'b0;
      end else if (run) begin
        out_reg  <= 1'b1;
        half_reg <= half_req;
      end else begin
        active_reg <= 1'b0;
      end
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  assign clk_out     = out_reg;
  assign active      = active_reg;
  assign half_active = half_reg;

endmodule

//--- rtl/crsp_map.vh
// Offsets, fields, reset values and timing counts for the supervisor
`ifndef CRSP_MAP_VH
`define CRSP_MAP_VH

// Timing
`define CRSP_CLK_MHZ        10
`define CRSP_TRST_US        135
`define CRSP_TRST_CYC       (`CRSP_TRST_US * `CRSP_CLK_MHZ)
`define CRSP_HALF_CYC       1
`define CRSP_TMR_W          16

// Reset output variants, fixed at build time
`define CRSP_RST_PP_HIGH    2'h0
`define CRSP_RST_PP_LOW     2'h1
`define CRSP_RST_OD_LOW     2'h2

// Register port
`define CRSP_ADDR_W         4
`define CRSP_DATA_W         16
`define CRSP_OFF_STATUS     4'h0
`define CRSP_OFF_CTRL       4'h4
`define CRSP_OFF_TIMER      4'h8
`define CRSP_OFF_BROWN      4'hc

// Control register fields
`define CRSP_CTRL_FORCE_HALF 0
`define CRSP_CTRL_PF_SLOWS   1
`define CRSP_CTRL_RESET      2'h0

// Status register fields
`define CRSP_ST_SUPPLY_OK   0
`define CRSP_ST_OSC_RUN     1
`define CRSP_ST_RST_ACT     2
`define CRSP_ST_PF_ACT      3
`define CRSP_ST_SRC_INT     4
`define CRSP_ST_HALF_ACT    5
`define CRSP_ST_RATE_PIN    6

`endif

//--- rtl/crsp_supervisor.v
// Clock, reset and power-fail supervisor top level
`timescale 1ns/1ps
`include "crsp_map.vh"

// Function
// - Rate select high gives full clock rate
// - Rate select low halves the clock exactly
// - Clock output never emits shortened phases
// - Oscillator starts only above rising trip
// - Reset held through power-up plus timeout
// - Timeout nominally 135 us from oscillator
// - Release reset at timeout if supply good
// - Reset whenever supply below trip level
// - Reset output variant chosen at build
// - Open-drain flag low below power-fail threshold
// - Monitor external divided voltage or supply
// - Power-fail flag on rate select halves clock
// - Sense level selects monitoring source
// - Reset asserts below falling trip level
module crsp_supervisor #(
  parameter [1:0] RST_VARIANT = `CRSP_RST_OD_LOW,
  parameter       HALF_CYC    = `CRSP_HALF_CYC
) (
  input  wire                    clk,
  input  wire                    rst_b,
  input  wire                    supply_above_rise,
  input  wire                    supply_below_fall,
  input  wire                    sense_below_sel_lo,
  input  wire                    sense_above_sel_hi,
  input  wire                    ext_below_pf,
  input  wire                    int_below_pf,
  input  wire                    rate_sel_in,
  input  wire [`CRSP_ADDR_W-1:0] reg_addr,
  input  wire [`CRSP_DATA_W-1:0] reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output wire [`CRSP_DATA_W-1:0] reg_rdata,
  output wire                    clock_out,
  output wire                    rst_out,
  output wire                    rst_oe,
  output wire                    power_fail_flag_n_out,
  output wire                    power_fail_flag_n_oe
);

  localparam [2:0] S_OFF  = 3'b001;
  localparam [2:0] S_HOLD = 3'b010;
  localparam [2:0] S_RUN  = 3'b100;

  // Counter width limits the timeout to what the timer field can hold
  localparam [31:0]            TRST_LAST_W = `CRSP_TRST_CYC - 1;
  localparam [`CRSP_TMR_W-1:0] TRST_LAST   = TRST_LAST_W[`CRSP_TMR_W-1:0];

  // Synchronised pin levels
  wire [6:0] pin_sync;
  wire       above_rise_s;
  wire       below_fall_s;
  wire       sel_lo_s;
  wire       sel_hi_s;
  wire       ext_pf_s;
  wire       int_pf_s;
  wire       rate_sel_s;

  // State
  reg  [2:0]              state_reg;
  reg  [2:0]              state_next;
  reg  [`CRSP_TMR_W-1:0]  tmr_reg;
  reg  [`CRSP_TMR_W-1:0]  tmr_next;
  reg                     supply_ok_reg;
  reg                     supply_ok_next;
  reg                     src_int_reg;
  reg                     src_int_next;
  reg                     pf_act_reg;
  reg  [1:0]              ctrl_reg;
  reg  [`CRSP_DATA_W-1:0] brown_reg;
  reg  [`CRSP_DATA_W-1:0] rdata_reg;
  reg  [`CRSP_DATA_W-1:0] rdata_next;
  reg                     rst_out_reg;
  reg                     rst_oe_reg;
  reg                     pf_oe_reg;

  wire                    pf_cond;
  wire                    osc_run;
  wire                    half_req;
  wire                    rst_assert;
  wire                    clk_active;
  wire                    half_active;
  wire [`CRSP_DATA_W-1:0] status_word;

  crsp_sync #(
    .WIDTH    (7)
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({rate_sel_in, int_below_pf, ext_below_pf, sense_above_sel_hi,
                sense_below_sel_lo, supply_below_fall, supply_above_rise}),
    .sync_out (pin_sync)
  );

  assign above_rise_s = pin_sync[0];
  assign below_fall_s = pin_sync[1];
  assign sel_lo_s     = pin_sync[2];
  assign sel_hi_s     = pin_sync[3];
  assign ext_pf_s     = pin_sync[4];
  assign int_pf_s     = pin_sync[5];
  assign rate_sel_s   = pin_sync[6];

  // Supply hysteresis: good from rising trip until below falling trip
  always @* begin
    supply_ok_next = supply_ok_reg;
    if (below_fall_s) begin
      supply_ok_next = 1'b0;
    end else if (above_rise_s) begin
      supply_ok_next = 1'b1;
    end
  end

  // Monitor source, held while the sense level sits between the bands
  always @* begin
    src_int_next = src_int_reg;
    if (sel_lo_s) begin
      src_int_next = 1'b0;
    end else if (sel_hi_s) begin
      src_int_next = 1'b1;
    end
  end

  assign pf_cond = src_int_reg ? int_pf_s : ext_pf_s;

  // Power-on sequencer
  always @* begin
    state_next = state_reg;
    tmr_next   = tmr_reg;
    case (state_reg)
      S_OFF: begin
        tmr_next = {`CRSP_TMR_W{1'b0}};
        if (supply_ok_reg) begin
          state_next = S_HOLD;
        end
      end
      S_HOLD: begin
        if (!supply_ok_reg) begin
          state_next = S_OFF;
          tmr_next   = {`CRSP_TMR_W{1'b0}};
        end else if (tmr_reg == TRST_LAST) begin
          state_next = S_RUN;
        end else begin
          tmr_next = tmr_reg + 1'b1;
        end
      end
      S_RUN: begin
        if (!supply_ok_reg) begin
          state_next = S_OFF;
          tmr_next   = {`CRSP_TMR_W{1'b0}};
        end
      end
      default: begin
        state_next = S_OFF;
        tmr_next   = {`CRSP_TMR_W{1'b0}};
      end
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= S_OFF;
      tmr_reg       <= {`CRSP_TMR_W{1'b0}};
      supply_ok_reg <= 1'b0;
      src_int_reg   <= 1'b0;
      pf_act_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      tmr_reg       <= tmr_next;
      supply_ok_reg <= supply_ok_next;
      src_int_reg   <= src_int_next;
      pf_act_reg    <= pf_cond;
    end
  end

  // Reset asserted in every state but run
  assign rst_assert = (state_reg != S_RUN);

  // Oscillator stops with the supply; clkgen finishes its period first
  assign osc_run = (state_reg != S_OFF);

  // Any slow request halves the rate; pin high alone means full rate
  assign half_req = !rate_sel_s
                    || ctrl_reg[`CRSP_CTRL_FORCE_HALF]
                    || (ctrl_reg[`CRSP_CTRL_PF_SLOWS] && pf_act_reg);

  crsp_clkgen #(
    .HALF_CYC    (HALF_CYC)
  ) u_clkgen (
    .clk         (clk),
    .rst_b       (rst_b),
    .run         (osc_run),
    .half_req    (half_req),
    .clk_out     (clock_out),
    .active      (clk_active),
    .half_active (half_active)
  );

  // Reset pin; one variant only per build
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_out_reg <= (RST_VARIANT == `CRSP_RST_PP_HIGH);
      rst_oe_reg  <= 1'b1;
    end else begin
      case (RST_VARIANT)
        `CRSP_RST_PP_HIGH: begin
          rst_out_reg <= rst_assert;
          rst_oe_reg  <= 1'b1;
        end
        `CRSP_RST_PP_LOW: begin
          rst_out_reg <= !rst_assert;
          rst_oe_reg  <= 1'b1;
        end
        default: begin
          rst_out_reg <= 1'b0;
          rst_oe_reg  <= rst_assert;
        end
      endcase
    end
  end

  // Power-fail flag pulls low only; release leaves the wire to the pull-up
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pf_oe_reg <= 1'b0;
    end else begin
      pf_oe_reg <= pf_cond;
    end
  end

  // Brownout counter: one count per fall out of run, saturating
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      brown_reg <= {`CRSP_DATA_W{1'b0}};
    end else if (reg_wr && reg_addr == `CRSP_OFF_BROWN) begin
      brown_reg <= {`CRSP_DATA_W{1'b0}};
      if (state_reg == S_RUN && !supply_ok_reg) begin
        brown_reg <= {{(`CRSP_DATA_W-1){1'b0}}, 1'b1};
      end
    end else if (state_reg == S_RUN && !supply_ok_reg && !(&brown_reg)) begin
      brown_reg <= brown_reg + 1'b1;
    end
  end

  // Control register
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `CRSP_CTRL_RESET;
    end else if (reg_wr && reg_addr == `CRSP_OFF_CTRL) begin
      ctrl_reg <= reg_wdata[1:0];
    end
  end

  assign status_word = {{(`CRSP_DATA_W-7){1'b0}},
                        rate_sel_s,
                        half_active,
                        src_int_reg,
                        pf_act_reg,
                        rst_assert,
                        clk_active,
                        supply_ok_reg};

  // Read data stand one cycle after the strobe, zero otherwise
  always @* begin
    rdata_next = {`CRSP_DATA_W{1'b0}};
    if (reg_rd) begin
      case (reg_addr)
        `CRSP_OFF_STATUS: rdata_next = status_word;
        `CRSP_OFF_CTRL:   rdata_next = {{(`CRSP_DATA_W-2){1'b0}}, ctrl_reg};
        `CRSP_OFF_TIMER:  rdata_next = tmr_reg;
        `CRSP_OFF_BROWN:  rdata_next = brown_reg;
        default:          rdata_next = {`CRSP_DATA_W{1'b0}};
      endcase
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= {`CRSP_DATA_W{1'b0}};
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata             = rdata_reg;
  assign rst_out               = rst_out_reg;
  assign rst_oe                = rst_oe_reg;
  assign power_fail_flag_n_out = 1'b0;
  assign power_fail_flag_n_oe  = pf_oe_reg;

endmodule

//--- rtl/crsp_sync.v
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module crsp_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

//--- tb/crsp_checker.sv
// Port checker for the supervisor, bound to its top module
`timescale 1ns/1ps
module crsp_checker #(
  parameter [1:0] RST_VARIANT = 2'h2,
  parameter       HALF_CYC    = 1
) (
  input wire clk,
  input wire rst_b,
  input wire supply_above_rise,
  input wire supply_below_fall,
  input wire sense_below_sel_lo,
  input wire sense_above_sel_hi,
  input wire ext_below_pf,
  input wire int_below_pf,
  input wire clock_out,
  input wire rst_out,
  input wire rst_oe,
  input wire power_fail_flag_n_oe
);
  wire       good = supply_above_rise && !supply_below_fall;
  wire       rst_act = (RST_VARIANT == 2'h0) ? rst_out : (rst_oe && !rst_out);
  reg [10:0] good_cnt;
  reg [7:0]  hi_cnt;
  reg [7:0]  lo_cnt;
  // Saturate so a long good run never wraps back into the hold window
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      good_cnt <= 11'h0;
      hi_cnt   <= 8'h0;
      lo_cnt   <= 8'h0;
    end else begin
      good_cnt <= good ? good_cnt + {10'h0, good_cnt != 11'h7ff} : 11'h0;
      hi_cnt   <= clock_out ? hi_cnt + {7'h0, hi_cnt != 8'hff} : 8'h0;
      lo_cnt   <= clock_out ? 8'h0 : lo_cnt + {7'h0, lo_cnt != 8'hff};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_high_phase: assert property (
    $fell(clock_out) |-> hi_cnt == HALF_CYC || hi_cnt == 2 * HALF_CYC) else $error("Bad phase");
  a_low_phase: assert property (
    $rose(clock_out) |-> lo_cnt >= HALF_CYC) else $error("Short low phase");
  a_reset_early: assert property (
    good_cnt != 11'h0 && good_cnt < 11'h546 |-> rst_act) else $error("Reset released early");
  a_release_due: assert property (
    good_cnt == 11'h553 |-> !rst_act) else $error("Reset not released");
  a_supply_low: assert property (
    (!good) [*7] |-> rst_act) else $error("No reset on low supply");
  a_osc_stop: assert property (
    (!good) [*8] ##1 (!good) [*8] |-> !clock_out) else $error("Clock not stopped");
  a_osc_start: assert property (
    good_cnt == 11'h00c |-> ##[0:4] $changed(clock_out)) else $error("Clock not started");
  a_pf_ext: assert property (
    (sense_below_sel_lo && $stable(ext_below_pf)) [*6] |-> power_fail_flag_n_oe == ext_below_pf)
    else $error("External flag wrong");
  a_pf_int: assert property (
    (sense_above_sel_hi && !sense_below_sel_lo && $stable(int_below_pf)) [*6]
    |-> power_fail_flag_n_oe == int_below_pf) else $error("Internal flag wrong");
  c_release: cover property ($fell(rst_act));
  c_flag: cover property ($rose(power_fail_flag_n_oe));
  c_half: cover property ($fell(clock_out) && hi_cnt == 2 * HALF_CYC);
endmodule
bind crsp_supervisor crsp_checker #(.RST_VARIANT(RST_VARIANT), .HALF_CYC(HALF_CYC)) chk_u (
  .clk, .rst_b, .supply_above_rise, .supply_below_fall, .sense_below_sel_lo,
  .sense_above_sel_hi, .ext_below_pf, .int_below_pf, .clock_out, .rst_out, .rst_oe,
  .power_fail_flag_n_oe);

//--- tb/crsp_mcu_model.sv
// Microcontroller clock and reset input model
`timescale 1ns/1ps
module crsp_mcu_model (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        clock_out,
  input  wire        rst_out,
  input  wire        rst_oe,
  output reg  [7:0]  period,
  output reg  [15:0] rises,
  output wire        in_reset
);
  reg [7:0] cnt;
  reg       last;
  // Pull-up on the reset net, so a released line reads high
  assign in_reset = !(rst_oe ? rst_out : 1'b1);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt    <= 8'h0;
      last   <= 1'b0;
      period <= 8'h0;
      rises  <= 16'h0;
    end else begin
      last <= clock_out;
      cnt  <= (clock_out && !last) ? 8'h1 : cnt + 8'h1;
      if (clock_out && !last) begin
        period <= cnt;
        rises  <= rises + 16'h1;
      end
    end
  end
endmodule

//--- tb/test_clock_reset_powerfail_supervisor.sv
// Self-checking bench for the clock, reset and power-fail supervisor
`timescale 1ns/1ps
module test_clock_reset_powerfail_supervisor;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         supply_above_rise = 1'b0;
  reg         supply_below_fall = 1'b1;
  reg         sense_below_sel_lo = 1'b1;
  reg         sense_above_sel_hi = 1'b0;
  reg         ext_below_pf = 1'b0;
  reg         int_below_pf = 1'b0;
  reg         rate_pin = 1'b1;
  reg         pf_wired = 1'b0;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [15:0] reg_wdata = 16'h0;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         rd_d = 1'b0;
  reg  [15:0] seed = 16'h0030;
  reg  [15:0] r;
  reg  [15:0] exp_q[$];
  integer     n;
  integer     mismatches = 0;
  integer     tests_run = 0;
  wire [15:0] reg_rdata;
  wire        clock_out, rst_out, rst_oe, in_reset;
  wire        power_fail_flag_n_out, power_fail_flag_n_oe;
  wire [7:0]  period;
  wire [15:0] rises;
  wire        pf_level = power_fail_flag_n_oe ? power_fail_flag_n_out : 1'b1;
  wire        rate_sel_in = pf_wired ? pf_level : rate_pin;

  crsp_supervisor #(.RST_VARIANT(2'h2), .HALF_CYC(2)) dut_u (.clk, .rst_b,
    .supply_above_rise, .supply_below_fall, .sense_below_sel_lo, .sense_above_sel_hi,
    .ext_below_pf, .int_below_pf, .rate_sel_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .clock_out, .rst_out, .rst_oe, .power_fail_flag_n_out, .power_fail_flag_n_oe);
  crsp_mcu_model mcu_u (.clk, .rst_b, .clock_out, .rst_out, .rst_oe, .period, .rises,
    .in_reset);

  always #50 clk = ~clk;

  task check(input [15:0] got, exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      check(reg_rdata, exp_q.pop_front());
    end
  end
  function [15:0] xorshift(input [15:0] x);
    begin
      x = x ^ (x << 7);
      x = x ^ (x >> 9);
      xorshift = x ^ (x << 8);
    end
  endfunction
  task tick(input integer k);
    repeat (k) @(posedge clk);
  endtask
  task reg_write(input [3:0] a, input [15:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      tick(1);
      reg_wr <= 1'b0;
      tick(1);
    end
  endtask
  task reg_read(input [3:0] a, input [15:0] e);
    begin
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      tick(1);
      reg_rd <= 1'b0;
      tick(2);
    end
  endtask
  task power_up;
    begin
      n = 0;
      supply_below_fall <= 1'b0;
      supply_above_rise <= 1'b1;
      while (in_reset === 1'b1 && n < 2000) begin
        tick(1);
        n = n + 1;
      end
      check({15'h0, n > 1349 && n < 1370}, 16'h1);
      $display("Power-up test done");
    end
  endtask
  task finish_test;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  initial begin
    tick(4);
    rst_b <= 1'b1;
    tick(20);
    check({15'h0, in_reset}, 16'h1);
    check(rises, 16'h0);
    power_up;
    reg_read(4'h0, 16'h0043);
    reg_read(4'h2, 16'h0000);
    reg_read(4'h8, 16'h0545);
    repeat (4) begin
      seed = xorshift(seed);
      reg_write(4'h4, seed);
      reg_read(4'h4, seed & 16'h0003);
    end
    reg_write(4'h4, 16'h0000);
    tick(30);
    check({8'h0, period}, 16'h4);
    rate_pin <= 1'b0;
    tick(40);
    check({8'h0, period}, 16'h8);
    reg_read(4'h0, 16'h0023);
    rate_pin <= 1'b1;
    reg_write(4'h4, 16'h0001);
    tick(40);
    check({8'h0, period}, 16'h8);
    reg_write(4'h4, 16'h0000);
    tick(40);
    check({8'h0, period}, 16'h4);
    $display("Rate test done");
    ext_below_pf <= 1'b1;
    pf_wired <= 1'b1;
    tick(40);
    check({15'h0, pf_level}, 16'h0);
    check({8'h0, period}, 16'h8);
    ext_below_pf <= 1'b0;
    tick(40);
    check({8'h0, period}, 16'h4);
    sense_below_sel_lo <= 1'b0;
    sense_above_sel_hi <= 1'b1;
    int_below_pf <= 1'b1;
    tick(40);
    reg_read(4'h0, 16'h003b);
    // Source must stay internal while the sense level sits between thresholds
    sense_above_sel_hi <= 1'b0;
    int_below_pf <= 1'b0;
    ext_below_pf <= 1'b1;
    tick(20);
    check({15'h0, pf_level}, 16'h1);
    sense_below_sel_lo <= 1'b1;
    tick(20);
    check({15'h0, pf_level}, 16'h0);
    ext_below_pf <= 1'b0;
    pf_wired <= 1'b0;
    $display("Power-fail test done");
    supply_below_fall <= 1'b1;
    tick(8);
    check({15'h0, in_reset}, 16'h1);
    supply_above_rise <= 1'b0;
    tick(20);
    r = rises;
    tick(20);
    check(rises, r);
    power_up;
    reg_read(4'h8, 16'h0545);
    reg_read(4'hc, 16'h0001);
    reg_write(4'hc, 16'hffff);
    reg_read(4'hc, 16'h0000);
    $display("Brownout test done");
    finish_test;
  end

  initial begin
    #2000000;
    mismatches = mismatches + 1;
    finish_test;
  end
endmodule
